// file: hdl/kbd_a20_ctl.sv
`timescale 1ns/1ns
// Overview of operation
// - Self-test command AA returns 55 in the output buffer.
// - Interface test AB returns 00 ok, 01 for clock line stuck low, 03 for data line stuck low.
// - AD disables, AE enables keyboard interface; C0 returns input port.
// - C1/C2 continuously copy low/high input nibble into status upper bits.
// - D0 returns the output port value.
// - D1 then data byte sets the A20 gate from data bit 1.
// - D2/D3 echo next data byte as keyboard or auxiliary data.
// - D4 sends next data byte to the auxiliary device.
// - E0 returns the test input levels.
// - Even Fx command pulses processor reset low for 6 us, except FE with hardware reset select.
// - Two-bit clock select chooses 6, 8, 12 or 16 MHz controller clock.
// - Fast-port enable lets the fast port drive A20 and keyboard reset.
// - Hardware A20 select bit is stored but leaves the A20 gate on output port bit 1.
// - Hardware reset select lets dedicated logic drive keyboard reset.
// - In hardware mode, D1 data bit 1 sets A20, bit 0 keyboard reset.
// - Hardware FE waits 14 us then drives keyboard reset low 6 us.
// - A20 and keyboard reset each use their own path, merged with fast port; processor reset is not merged.
// - Fast port resets to 24h; bits 5 and 2 read 1, bits 1 and 0 are writable, others reserved 0.
// - Fast A20 level bit, when set, forces the A20 gate high; clear leaves output port bit 1.
// - Fast reset bit gives delayed 6 us low pulse; clear before next.
// - Data-port write marks data, command-port write marks command.
// - Status shows output full, input full and last write command flag.
module kbd_a20_ctl
  import kbd_ctl_pkg::*;
(
  input wire logic i_clk,               // 125 MHz system clock.
  input wire logic i_reset_n,           // Asynchronous reset, active low.
  input wire logic [7:0] i_addr,        // Host I/O address low byte.
  input wire logic [7:0] i_wdata,       // Host write data.
  input wire logic i_wr,                // Host write strobe, one cycle.
  input wire logic i_rd,                // Host read strobe, one cycle.
  input wire logic [7:0] i_input_port,  // Input port pins, asynchronous.
  input wire logic [1:0] i_test_in,     // Test inputs, asynchronous.
  input wire logic i_kbd_clk_in,        // Keyboard clock line level.
  input wire logic i_kbd_dat_in,        // Keyboard data line level.
  output logic [7:0] o_rdata,           // Host read data, registered.
  output logic o_a20_gate_line,         // Address-20 gate.
  output logic o_keyboard_reset_out_n,  // Keyboard reset, active low.
  output logic o_processor_reset_out_n, // Processor reset, active low.
  output logic o_kbd_enabled,           // Keyboard interface enabled.
  output logic o_aux_tx_valid,          // Byte for auxiliary device, pulse.
  output logic o_kbd_tx_valid,          // Byte for keyboard, pulse.
  output logic [7:0] o_tx_data,         // Byte to the serial side.
  output logic [1:0] o_clock_rate_sel   // Controller clock select.
);
  // Two-stage synchronisers for all pins.
  logic [11:0] sync1_r, sync2_r;
  logic [7:0] inp_s;
  logic [1:0] test_s;
  logic kclk_s, kdat_s;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_kbd_dat_in, i_kbd_clk_in, i_test_in, i_input_port};
      sync2_r <= sync1_r;
    end
  end
  assign inp_s = sync2_r[7:0];
  assign test_s = sync2_r[9:8];
  assign kclk_s = sync2_r[10];
  assign kdat_s = sync2_r[11];

  reset_pulse_if cpu_rp();
  reset_pulse_if kbd_rp();
  reset_pulse_gen u_cpu_pulse (.i_clk(i_clk), .i_reset_n(i_reset_n), .rp(cpu_rp));
  reset_pulse_gen u_kbd_pulse (.i_clk(i_clk), .i_reset_n(i_reset_n), .rp(kbd_rp));

  logic [7:0] hwctl_r, hwctl_nxt;
  logic [7:0] fast_r, fast_nxt;
  logic [7:0] outbuf_r, outbuf_nxt;
  logic [7:0] outport_r, outport_nxt;
  logic [3:0] poll_r, poll_nxt;
  logic [1:0] poll_mode_r, poll_mode_nxt;
  logic obf_r, obf_nxt, aux_r, aux_nxt, cmd_flag_r, cmd_flag_nxt;
  logic kbd_en_r, kbd_en_nxt, to_aux_r, to_aux_nxt;
  pend_e pend_r, pend_nxt;
  logic [7:0] rdata_nxt;
  logic a20_nxt, krst_n_nxt, cpu_n_nxt;
  logic auxv_nxt, kbdv_nxt;
  logic [7:0] tx_nxt;
  logic cpu_start, kbd_start, kbd_delay;
  logic fast_pulse_rise;

  function automatic logic [7:0] if_test(input logic clk, input logic dat);
    if (!clk) return IF_CLK_LOW;
    if (!dat) return IF_DAT_LOW;
    return IF_OK;
  endfunction : if_test

  function automatic logic [7:0] status_byte(input logic obf, input logic cmd,
                                             input logic inh, input logic aux,
                                             input logic [1:0] mode,
                                             input logic [3:0] nib);
    logic [7:0] s;
    s = '0;
    s[ST_OBF] = obf;
    s[ST_IBF] = 1'b0;           // Input is consumed the cycle it is written.
    s[ST_CMD] = cmd;
    s[ST_INH] = inh;
    s[ST_AUX] = aux;
    if (mode != 2'b00) s[7:4] = nib;
    return s;
  endfunction : status_byte

  wire wr_cmd = i_wr && (i_addr == ADDR_CMD);
  wire wr_dat = i_wr && (i_addr == ADDR_DATA);
  wire hw_a20 = hwctl_r[HW_A20_BIT];
  wire hw_krst = hwctl_r[HW_KRST_BIT];
  wire fast_en = hwctl_r[FAST_EN_BIT];
  assign fast_pulse_rise = fast_nxt[FAST_PULSE_BIT] && !fast_r[FAST_PULSE_BIT];

  always_comb begin
    hwctl_nxt = hwctl_r;
    fast_nxt = fast_r;
    outbuf_nxt = outbuf_r;
    outport_nxt = outport_r;
    poll_mode_nxt = poll_mode_r;
    poll_nxt = poll_r;
    obf_nxt = obf_r;
    aux_nxt = aux_r;
    cmd_flag_nxt = cmd_flag_r;
    kbd_en_nxt = kbd_en_r;
    to_aux_nxt = to_aux_r;
    pend_nxt = pend_r;
    auxv_nxt = 1'b0;
    kbdv_nxt = 1'b0;
    tx_nxt = o_tx_data;
    cpu_start = 1'b0;
    kbd_start = 1'b0;
    kbd_delay = 1'b1;
    rdata_nxt = o_rdata;

    if (poll_mode_r == 2'b01) poll_nxt = inp_s[3:0];
    if (poll_mode_r == 2'b10) poll_nxt = inp_s[7:4];

    if (i_rd) begin
      case (i_addr)
        ADDR_DATA: begin
          rdata_nxt = outbuf_r;
          obf_nxt = 1'b0;
          aux_nxt = 1'b0;
        end
        ADDR_CMD: rdata_nxt = status_byte(obf_r, cmd_flag_r, kbd_en_r, aux_r,
                                          poll_mode_r, poll_r);
        ADDR_HWCTL: rdata_nxt = hwctl_r;
        ADDR_FAST: rdata_nxt = fast_r | FAST_FIXED_ONES;
        default: rdata_nxt = BYTE_RESET;
      endcase
    end

    if (i_wr && i_addr == ADDR_HWCTL) begin
      hwctl_nxt = i_wdata & HWCTL_RW_MASK;
    end
    if (i_wr && i_addr == ADDR_FAST) begin
      fast_nxt = (i_wdata & 8'h03) | FAST_FIXED_ONES;
    end

    if (wr_cmd) begin
      cmd_flag_nxt = 1'b1;
      pend_nxt = PEND_NONE;
      to_aux_nxt = 1'b0;
      poll_mode_nxt = 2'b00;
      case (i_wdata)
        CMD_SELF_TEST: begin
          outbuf_nxt = SELF_TEST_OK;
          obf_nxt = 1'b1;
        end
        CMD_IF_TEST: begin
          outbuf_nxt = if_test(kclk_s, kdat_s);
          obf_nxt = 1'b1;
        end
        CMD_KBD_DIS: kbd_en_nxt = 1'b0;
        CMD_KBD_EN: kbd_en_nxt = 1'b1;
        CMD_RD_INPUT: begin
          outbuf_nxt = inp_s;
          obf_nxt = 1'b1;
        end
        CMD_POLL_LO: poll_mode_nxt = 2'b01;
        CMD_POLL_HI: poll_mode_nxt = 2'b10;
        CMD_RD_OUTPORT: begin
          outbuf_nxt = outport_r;
          obf_nxt = 1'b1;
        end
        CMD_WR_OUTPORT: pend_nxt = PEND_OUTPORT;
        CMD_ECHO_KBD: pend_nxt = PEND_ECHO_KBD;
        CMD_ECHO_AUX: pend_nxt = PEND_ECHO_AUX;
        CMD_TO_AUX: to_aux_nxt = 1'b1;
        CMD_RD_TEST: begin
          outbuf_nxt = {6'h00, test_s};
          obf_nxt = 1'b1;
        end
        default: begin
          // With hardware reset select, the hardware path catches FE itself, so the firmware pulse skips it.
          if (i_wdata[7:4] == CMD_PULSE_HI && !i_wdata[0]) begin
            if (hw_krst && i_wdata == CMD_HW_RESET) begin
              kbd_start = !kbd_rp.busy;
            end else begin
              cpu_start = !cpu_rp.busy;
            end
          end
        end
      endcase
    end else if (wr_dat) begin
      cmd_flag_nxt = 1'b0;
      pend_nxt = PEND_NONE;
      case (pend_r)
        PEND_OUTPORT: begin
          outport_nxt[1] = i_wdata[1];
          if (hw_krst) outport_nxt[0] = i_wdata[0];
        end
        PEND_ECHO_KBD: begin
          outbuf_nxt = i_wdata;
          obf_nxt = 1'b1;
          aux_nxt = 1'b0;
        end
        PEND_ECHO_AUX: begin
          outbuf_nxt = i_wdata;
          obf_nxt = 1'b1;
          aux_nxt = 1'b1;
        end
        // Plain data goes to the keyboard, if enabled, unless D4 armed the auxiliary route.
        default: begin
          tx_nxt = i_wdata;
          auxv_nxt = to_aux_r;
          kbdv_nxt = !to_aux_r && kbd_en_r;
          to_aux_nxt = 1'b0;
        end
      endcase
    end

    // Only a 0 to 1 write of the bit fires, so software must clear it before the next request.
    if (fast_en && fast_pulse_rise && !kbd_rp.busy) begin
      kbd_start = 1'b1;
    end

    // The A20 gate follows output port bit 1 whether or not hardware A20 is selected.
    a20_nxt = outport_r[1];
    if (!hw_a20) a20_nxt = outport_r[1];
    if (fast_en) a20_nxt = a20_nxt | fast_r[FAST_A20_BIT];
    krst_n_nxt = !kbd_rp.low;
    if (hw_krst) krst_n_nxt = krst_n_nxt & outport_r[0];
    cpu_n_nxt = !cpu_rp.low;
  end

  assign cpu_rp.start = cpu_start;
  assign cpu_rp.with_delay = 1'b0;
  assign kbd_rp.start = kbd_start;
  assign kbd_rp.with_delay = kbd_delay;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hwctl_r <= HWCTL_RESET;
      fast_r <= FAST_RESET;
      outbuf_r <= BYTE_RESET;
      outport_r <= OUTPORT_RESET;
      poll_mode_r <= 2'b00;
      poll_r <= 4'h0;
      obf_r <= 1'b0;
      aux_r <= 1'b0;
      cmd_flag_r <= 1'b0;
      kbd_en_r <= 1'b1;
      to_aux_r <= 1'b0;
      pend_r <= PEND_NONE;
      o_rdata <= BYTE_RESET;
      o_a20_gate_line <= 1'b1;
      o_keyboard_reset_out_n <= 1'b1;
      o_processor_reset_out_n <= 1'b1;
      o_kbd_enabled <= 1'b1;
      o_aux_tx_valid <= 1'b0;
      o_kbd_tx_valid <= 1'b0;
      o_tx_data <= BYTE_RESET;
      o_clock_rate_sel <= 2'b00;
    end else begin
      hwctl_r <= hwctl_nxt;
      fast_r <= fast_nxt;
      outbuf_r <= outbuf_nxt;
      outport_r <= outport_nxt;
      poll_mode_r <= poll_mode_nxt;
      poll_r <= poll_nxt;
      obf_r <= obf_nxt;
      aux_r <= aux_nxt;
      cmd_flag_r <= cmd_flag_nxt;
      kbd_en_r <= kbd_en_nxt;
      to_aux_r <= to_aux_nxt;
      pend_r <= pend_nxt;
      o_rdata <= rdata_nxt;
      o_a20_gate_line <= a20_nxt;
      o_keyboard_reset_out_n <= krst_n_nxt;
      o_processor_reset_out_n <= cpu_n_nxt;
      o_kbd_enabled <= kbd_en_nxt;
      o_aux_tx_valid <= auxv_nxt;
      o_kbd_tx_valid <= kbdv_nxt;
      o_tx_data <= tx_nxt;
      o_clock_rate_sel <= hwctl_nxt[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT];
    end
  end
endmodule : kbd_a20_ctl

// file: hdl/kbd_ctl_pkg.sv
package kbd_ctl_pkg;

  // Host port addresses (low byte of the I/O address).
  localparam logic [7:0] ADDR_DATA = 8'h60;
  localparam logic [7:0] ADDR_CMD = 8'h64;
  localparam logic [7:0] ADDR_FAST = 8'h92;
  localparam logic [7:0] ADDR_HWCTL = 8'hF0;

  // Command codes.
  localparam logic [7:0] CMD_SELF_TEST = 8'hAA;
  localparam logic [7:0] CMD_IF_TEST = 8'hAB;
  localparam logic [7:0] CMD_KBD_DIS = 8'hAD;
  localparam logic [7:0] CMD_KBD_EN = 8'hAE;
  localparam logic [7:0] CMD_RD_INPUT = 8'hC0;
  localparam logic [7:0] CMD_POLL_LO = 8'hC1;
  localparam logic [7:0] CMD_POLL_HI = 8'hC2;
  localparam logic [7:0] CMD_RD_OUTPORT = 8'hD0;
  localparam logic [7:0] CMD_WR_OUTPORT = 8'hD1;
  localparam logic [7:0] CMD_ECHO_KBD = 8'hD2;
  localparam logic [7:0] CMD_ECHO_AUX = 8'hD3;
  localparam logic [7:0] CMD_TO_AUX = 8'hD4;
  localparam logic [7:0] CMD_RD_TEST = 8'hE0;
  localparam logic [7:0] CMD_HW_RESET = 8'hFE;
  localparam logic [3:0] CMD_PULSE_HI = 4'hF;

  // Answers.
  localparam logic [7:0] SELF_TEST_OK = 8'h55;
  localparam logic [7:0] IF_OK = 8'h00;
  localparam logic [7:0] IF_CLK_LOW = 8'h01;
  localparam logic [7:0] IF_CLK_HIGH = 8'h02;
  localparam logic [7:0] IF_DAT_LOW = 8'h03;
  localparam logic [7:0] IF_DAT_HIGH = 8'h04;

  // Status bit positions.
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_CMD = 3;
  localparam int ST_INH = 4;
  localparam int ST_AUX = 5;

  // Control register field positions.
  localparam int HW_KRST_BIT = 0;
  localparam int HW_A20_BIT = 1;
  localparam int FAST_EN_BIT = 2;
  localparam int CLK_SEL_LO_BIT = 6;
  localparam int CLK_SEL_HI_BIT = 7;
  localparam logic [7:0] HWCTL_RW_MASK = 8'hC7;
  localparam logic [7:0] HWCTL_RESET = 8'h00;

  // Fast port.
  localparam logic [7:0] FAST_RESET = 8'h24;
  localparam logic [7:0] FAST_FIXED_ONES = 8'h24;
  localparam int FAST_PULSE_BIT = 0;
  localparam int FAST_A20_BIT = 1;

  // Reset values.
  localparam logic [7:0] OUTPORT_RESET = 8'h03;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Timing.
  localparam int CLK_MHZ = 125;
  localparam int PULSE_US = 6;
  localparam int DELAY_US = 14;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int DELAY_CYC = DELAY_US * CLK_MHZ;
  localparam int TMR_W = 12;

  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_OUTPORT,
    PEND_ECHO_KBD,
    PEND_ECHO_AUX
  } pend_e;

endpackage : kbd_ctl_pkg

// file: hdl/reset_pulse_if.sv
`timescale 1ns/1ns
interface reset_pulse_if;
  logic start;
  logic with_delay;
  logic busy;
  logic low;
  modport ctl (output start, output with_delay, input busy, input low);
  modport gen (input start, input with_delay, output busy, output low);
endinterface : reset_pulse_if

// file: hdl/reset_pulse_gen.sv
`timescale 1ns/1ns
module reset_pulse_gen
  import kbd_ctl_pkg::*;
(
  input wire logic i_clk,       // System clock.
  input wire logic i_reset_n,   // Asynchronous reset, active low.
  reset_pulse_if.gen rp         // Request and pulse level.
);
  typedef enum logic [1:0] {IDLE, WAIT, PULSE} pstate_e;
  pstate_e state_r, state_nxt;
  logic [TMR_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      IDLE: begin
        if (rp.start) begin
          if (rp.with_delay) begin
            state_nxt = WAIT;
            cnt_nxt = TMR_W'(DELAY_CYC - 1);
          end else begin
            state_nxt = PULSE;
            cnt_nxt = TMR_W'(PULSE_CYC - 1);
          end
        end
      end
      WAIT: begin
        if (cnt_r == '0) begin
          state_nxt = PULSE;
          cnt_nxt = TMR_W'(PULSE_CYC - 1);
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      PULSE: begin
        if (cnt_r == '0) begin
          state_nxt = IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign rp.busy = (state_r != IDLE);
  assign rp.low = (state_r == PULSE);
endmodule : reset_pulse_gen

// file: test/kbd_a20_checker.sv
`timescale 1ns/1ns
module kbd_a20_checker
  import kbd_ctl_pkg::*;
(
  input wire logic i_clk,                   // Clock.
  input wire logic i_reset_n,               // Reset, active low.
  input wire logic [7:0] i_addr,            // Host address.
  input wire logic [7:0] i_wdata,           // Host write data.
  input wire logic i_wr,                    // Write strobe.
  input wire logic i_rd,                    // Read strobe.
  input wire logic [7:0] o_rdata,           // Read data.
  input wire logic o_a20_gate_line,         // Address-20 gate.
  input wire logic o_keyboard_reset_out_n,  // Keyboard reset.
  input wire logic o_processor_reset_out_n, // Processor reset.
  input wire logic o_kbd_enabled,           // Keyboard enabled.
  input wire logic o_aux_tx_valid,          // Aux byte pulse.
  input wire logic o_kbd_tx_valid,          // Keyboard byte pulse.
  input wire logic [1:0] o_clock_rate_sel   // Clock select.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic [TMR_W-1:0] proc_low_r;
  logic [TMR_W-1:0] proc_low_nxt;
  logic cmd_wr;
  logic fx_even;
  logic data_wr;
  logic hw_wr;
  logic dis_wr;
  assign cmd_wr = i_wr && i_addr == ADDR_CMD;
  assign fx_even = cmd_wr && i_wdata[7:4] == CMD_PULSE_HI && !i_wdata[0];
  assign data_wr = i_wr && i_addr == ADDR_DATA;
  assign hw_wr = i_wr && i_addr == ADDR_HWCTL;
  assign dis_wr = cmd_wr && i_wdata == CMD_KBD_DIS;
  // Counts the low cycles of the processor reset so the full width is checked at its end.
  always_comb begin
    proc_low_nxt = o_processor_reset_out_n ? '0 : proc_low_r + 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      proc_low_r <= '0;
    end else begin
      proc_low_r <= proc_low_nxt;
    end
  end
  property p_clk_sel;
    hw_wr |=> o_clock_rate_sel == $past(i_wdata[7:6]);
  endproperty
  proc_width_a: assert property ($rose(o_processor_reset_out_n) |->
    proc_low_r == TMR_W'(PULSE_CYC)) else $error("processor reset width wrong");
  proc_cause_a: assert property ($fell(o_processor_reset_out_n) |->
    $past(fx_even, 2) || $past(fx_even, 3) || $past(fx_even, 4))
    else $error("processor reset without even Fx command");
  a20_cause_a: assert property ($changed(o_a20_gate_line) |->
    $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)) else $error("a20 moved without write");
  aux_cause_a: assert property (o_aux_tx_valid |->
    $past(data_wr) || $past(data_wr, 2)) else $error("aux byte without data write");
  tx_excl_a: assert property (!(o_aux_tx_valid && o_kbd_tx_valid))
    else $error("byte sent to both devices");
  clk_sel_a: assert property (p_clk_sel)
    else $error("clock select not taken from write");
  clk_hold_a: assert property ($changed(o_clock_rate_sel) |->
    $past(hw_wr) || $past(hw_wr, 2)) else $error("clock select moved alone");
  kbd_dis_a: assert property ($fell(o_kbd_enabled) |->
    $past(dis_wr) || $past(dis_wr, 2)) else $error("keyboard disabled without command");
  rdata_hold_a: assert property ($changed(o_rdata) |->
    $past(i_rd) || $past(i_rd, 2)) else $error("read data moved without read");
  cover property ($rose(o_processor_reset_out_n));
  cover property ($fell(o_keyboard_reset_out_n));
  cover property (o_aux_tx_valid);
endmodule : kbd_a20_checker

bind kbd_a20_ctl kbd_a20_checker i_kbd_a20_checker (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_a20_gate_line(o_a20_gate_line), .o_keyboard_reset_out_n(o_keyboard_reset_out_n),
  .o_processor_reset_out_n(o_processor_reset_out_n), .o_kbd_enabled(o_kbd_enabled),
  .o_aux_tx_valid(o_aux_tx_valid), .o_kbd_tx_valid(o_kbd_tx_valid),
  .o_clock_rate_sel(o_clock_rate_sel));

// file: test/host_bus_model.sv
`timescale 1ns/1ns
module host_bus_model (
  input wire logic i_clk,          // Bus clock.
  input wire logic [7:0] i_rdata,  // Read data from the controller.
  output logic [7:0] o_addr,       // Port address.
  output logic [7:0] o_wdata,      // Write data.
  output logic o_wr,               // Write strobe.
  output logic o_rd                // Read strobe.
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Released lines are inverted so that a stale value is never taken by luck.
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask : bus_read
endmodule : host_bus_model

// file: test/kbd_a20_ctl_tb.sv
`timescale 1ns/1ns
module kbd_a20_ctl_tb;
  import kbd_ctl_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [7:0] i_input_port;
  logic [1:0] i_test_in;
  logic i_kbd_clk_in;
  logic i_kbd_dat_in;
  logic [7:0] o_rdata;
  logic o_a20_gate_line;
  logic o_keyboard_reset_out_n;
  logic o_processor_reset_out_n;
  logic o_kbd_enabled;
  logic o_aux_tx_valid;
  logic o_kbd_tx_valid;
  logic [7:0] o_tx_data;
  logic [1:0] o_clock_rate_sel;
  logic [7:0] aux_seen = 8'h00;
  logic [7:0] kbd_seen = 8'h00;
  int mismatches = 0;
  int n_compared = 0;
  int dly;
  int wid;
  kbd_a20_ctl i_kbd_a20_ctl (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_input_port(i_input_port),
    .i_test_in(i_test_in), .i_kbd_clk_in(i_kbd_clk_in), .i_kbd_dat_in(i_kbd_dat_in),
    .o_rdata(o_rdata), .o_a20_gate_line(o_a20_gate_line),
    .o_keyboard_reset_out_n(o_keyboard_reset_out_n),
    .o_processor_reset_out_n(o_processor_reset_out_n), .o_kbd_enabled(o_kbd_enabled),
    .o_aux_tx_valid(o_aux_tx_valid), .o_kbd_tx_valid(o_kbd_tx_valid),
    .o_tx_data(o_tx_data), .o_clock_rate_sel(o_clock_rate_sel));
  host_bus_model i_host_bus_model (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_aux_tx_valid === 1'b1) aux_seen <= o_tx_data;
    if (o_kbd_tx_valid === 1'b1) kbd_seen <= o_tx_data;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_bus_model.bus_write(a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] v;
    i_host_bus_model.bus_read(a, v);
    chk_byte(v & m, e & m);
  endtask : rd_chk
  // Outputs follow a write by two cycles and pins need two to synchronise.
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic pins(input logic [7:0] p, input logic c, input logic d);
    @(posedge i_clk);
    i_input_port <= p;
    i_kbd_clk_in <= c;
    i_kbd_dat_in <= d;
    settle;
  endtask : pins
  function automatic logic lvl(input bit kbd);
    return kbd ? o_keyboard_reset_out_n : o_processor_reset_out_n;
  endfunction : lvl
  task automatic pulse(input bit kbd, output int d, output int w);
    d = 0;
    w = 0;
    while (lvl(kbd) === 1'b1 && d < 4000) begin
      @(posedge i_clk);
      #1;
      d++;
    end
    while (lvl(kbd) === 1'b0 && w < 4000) begin
      @(posedge i_clk);
      #1;
      w++;
    end
  endtask : pulse
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    $display("watchdog expired at %0t", $time);
    test_done;
  end
  initial begin
    i_reset_n = 1'b0;
    i_input_port = 8'hA5;
    i_test_in = 2'h2;
    i_kbd_clk_in = 1'b1;
    i_kbd_dat_in = 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd_chk(ADDR_FAST, FAST_RESET, 8'hFF);
    rd_chk(ADDR_HWCTL, HWCTL_RESET, 8'hFF);
    chk_byte({7'h0, o_a20_gate_line}, 8'h01);
    $display("reset test done");
    wr(ADDR_CMD, CMD_SELF_TEST);
    rd_chk(ADDR_CMD, 8'h09, 8'h0B);
    rd_chk(ADDR_DATA, SELF_TEST_OK, 8'hFF);
    rd_chk(ADDR_CMD, 8'h08, 8'h09);
    for (int k = 0; k < 3; k++) begin
      pins(8'hA5, k != 1, k != 2);
      wr(ADDR_CMD, CMD_IF_TEST);
      rd_chk(ADDR_DATA, k == 0 ? IF_OK : k == 1 ? IF_CLK_LOW : IF_DAT_LOW, 8'hFF);
    end
    $display("self test done");
    wr(ADDR_CMD, CMD_KBD_DIS);
    settle;
    chk_byte({7'h0, o_kbd_enabled}, 8'h00);
    wr(ADDR_CMD, CMD_KBD_EN);
    settle;
    chk_byte({7'h0, o_kbd_enabled}, 8'h01);
    wr(ADDR_CMD, CMD_RD_INPUT);
    rd_chk(ADDR_DATA, 8'hA5, 8'hFF);
    wr(ADDR_CMD, CMD_POLL_LO);
    rd_chk(ADDR_CMD, 8'h50, 8'hF0);
    pins(8'h3C, 1'b1, 1'b1);
    rd_chk(ADDR_CMD, 8'hC0, 8'hF0);
    wr(ADDR_CMD, CMD_POLL_HI);
    rd_chk(ADDR_CMD, 8'h30, 8'hF0);
    wr(ADDR_CMD, CMD_RD_TEST);
    rd_chk(ADDR_DATA, 8'h02, 8'h03);
    wr(ADDR_CMD, CMD_RD_OUTPORT);
    rd_chk(ADDR_DATA, OUTPORT_RESET, 8'hFF);
    $display("port test done");
    wr(ADDR_CMD, CMD_WR_OUTPORT);
    wr(ADDR_DATA, 8'h00);
    rd_chk(ADDR_CMD, 8'h00, 8'h08);
    settle;
    chk_byte({6'h0, o_a20_gate_line, o_keyboard_reset_out_n}, 8'h01);
    wr(ADDR_HWCTL, 8'h04);
    wr(ADDR_FAST, 8'hFE);
    settle;
    chk_byte({7'h0, o_a20_gate_line}, 8'h01);
    rd_chk(ADDR_FAST, 8'h26, 8'hFF);
    wr(ADDR_HWCTL, 8'h00);
    settle;
    chk_byte({7'h0, o_a20_gate_line}, 8'h00);
    wr(ADDR_HWCTL, 8'h04);
    wr(ADDR_FAST, 8'h01);
    pulse(1'b1, dly, wid);
    chk_cnt(dly >= DELAY_CYC, 1);
    chk_cnt(wid, PULSE_CYC);
    wr(ADDR_FAST, 8'h01);
    pulse(1'b1, dly, wid);
    chk_cnt(wid, 0);
    wr(ADDR_FAST, 8'h00);
    $display("fast port test done");
    wr(ADDR_CMD, 8'hF0);
    pulse(1'b0, dly, wid);
    chk_cnt(wid, PULSE_CYC);
    wr(ADDR_CMD, 8'hF1);
    settle;
    chk_byte({7'h0, o_processor_reset_out_n}, 8'h01);
    wr(ADDR_HWCTL, 8'h03);
    wr(ADDR_CMD, CMD_WR_OUTPORT);
    wr(ADDR_DATA, 8'h02);
    settle;
    chk_byte({6'h0, o_a20_gate_line, o_keyboard_reset_out_n}, 8'h02);
    wr(ADDR_CMD, CMD_WR_OUTPORT);
    wr(ADDR_DATA, 8'h03);
    settle;
    chk_byte({6'h0, o_a20_gate_line, o_keyboard_reset_out_n}, 8'h03);
    wr(ADDR_CMD, CMD_HW_RESET);
    pulse(1'b1, dly, wid);
    chk_cnt(dly >= DELAY_CYC, 1);
    chk_cnt(wid, PULSE_CYC);
    $display("reset pulse test done");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_HWCTL, {k[1:0], 6'h03});
      settle;
      chk_byte({6'h0, o_clock_rate_sel}, {6'h0, k[1:0]});
    end
    wr(ADDR_HWCTL, 8'hFF);
    rd_chk(ADDR_HWCTL, HWCTL_RW_MASK, 8'hFF);
    wr(ADDR_CMD, CMD_ECHO_KBD);
    wr(ADDR_DATA, 8'h5A);
    rd_chk(ADDR_CMD, 8'h01, 8'h21);
    rd_chk(ADDR_DATA, 8'h5A, 8'hFF);
    wr(ADDR_CMD, CMD_ECHO_AUX);
    wr(ADDR_DATA, 8'hA7);
    rd_chk(ADDR_CMD, 8'h21, 8'h21);
    rd_chk(ADDR_DATA, 8'hA7, 8'hFF);
    wr(ADDR_CMD, CMD_TO_AUX);
    wr(ADDR_DATA, 8'h3C);
    wr(ADDR_DATA, 8'hC3);
    settle;
    chk_byte(aux_seen, 8'h3C);
    chk_byte(kbd_seen, 8'hC3);
    $display("echo test done");
    test_done;
  end
endmodule : kbd_a20_ctl_tb
